// ### core/stat_read_pkg.sv
// constants shared by the indirect statistics read path and its counter cells
// assumes one 100 MHz clock and a byte-wide internal register port
package stat_read_pkg;

   // register byte addresses
   localparam logic [7:0] ADDR_TABLE_SELECT = 8'h79;
   localparam logic [7:0] ADDR_ADDRESS_TRIGGER = 8'h7a;
   localparam logic [7:0] ADDR_RESULT_TOP = 8'h80;
   localparam logic [7:0] ADDR_RESULT_BYTE2 = 8'h81;
   localparam logic [7:0] ADDR_RESULT_BYTE1 = 8'h82;
   localparam logic [7:0] ADDR_RESULT_BYTE0 = 8'h83;

   // reset values
   localparam logic [7:0] TABLE_SELECT_RESET = 8'h00;
   localparam logic [7:0] ADDRESS_TRIGGER_RESET = 8'h00;

   // table select codes
   localparam logic [7:0] SEL_PER_PORT = 8'h1c;
   localparam logic [7:0] SEL_DROPPED = 8'h1d;

   // indirect offset space: per-port block of 32, dropped counters at 0x100
   localparam int PORT_COUNT = 3;
   localparam int PORT_BLOCK = 32;
   localparam int PER_PORT_CELLS = PORT_COUNT * PORT_BLOCK;
   localparam int DROP_CELLS = 6;
   localparam logic [9:0] DROP_BASE = 10'h100;
   localparam logic [4:0] OFS_RX_FRAMES_LEN_SIXTY_FOUR = 5'h0e;
   localparam logic [7:0] PER_PORT_LIMIT = 8'h60;
   localparam logic [7:0] DROP_LIMIT = 8'h06;

   // counter widths and result field positions
   localparam int PER_PORT_WIDTH = 30;
   localparam int DROP_WIDTH = 16;
   localparam int INC_WIDTH = 16;
   localparam int BIT_OVERFLOW = 7;
   localparam int BIT_VALID = 6;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_FETCH = 2'b10
   } read_state_type;

endpackage

// ### core/counter_cell.sv
// one statistics counter: adds an increment, clears on request, flags wrap
// assumes increment and clear come from logic on the same clock
`timescale 1ns/100ps
`default_nettype none
module counter_cell #(
   parameter int WIDTH = 30
) (
   input wire logic clock, // system clock
   input wire logic reset_n, // synchronous reset, active low
   input wire logic incEn, // add incAmount this cycle
   input wire logic [stat_read_pkg::INC_WIDTH-1:0] incAmount, // increment size
   input wire logic clearEn, // clear value and overflow this cycle
   output logic [WIDTH-1:0] count, // current value
   output logic overflow // sticky wrap flag
);

   typedef struct packed {
      logic [WIDTH-1:0] count;
      logic overflow;
   } cell_state_type;

   cell_state_type s_r;
   cell_state_type s_nxt;

   // an increment landing with a clear is kept: it starts the new count
   always_comb begin
      logic [WIDTH:0] sum;
      sum = '0;
      s_nxt = s_r;
      if (clearEn) begin
         s_nxt.count = '0;
         s_nxt.overflow = 1'b0;
      end
      if (incEn) begin
         sum = {1'b0, s_nxt.count} + (WIDTH+1)'(incAmount);
         s_nxt.count = sum[WIDTH-1:0];
         if (sum[WIDTH]) begin
            s_nxt.overflow = 1'b1;
         end
      end
   end

   // state register
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign count = s_r.count;
   assign overflow = s_r.overflow;

endmodule
`default_nettype wire

// ### core/statistics_counter_indirect_read.sv
// indirect read path to the per-port and dropped-packet statistics counters
// assumes the management front end presents one-cycle byte register strobes on
// this clock, and that counter events arrive as offset-addressed increments
`timescale 1ns/100ps
`default_nettype none
module statistics_counter_indirect_read (
   input wire logic clock, // system clock, 100 MHz
   input wire logic reset_n, // synchronous reset, active low
   input wire logic regWrite, // one-cycle register write strobe
   input wire logic regRead, // one-cycle register read strobe
   input wire logic [7:0] regAddr, // register byte address
   input wire logic [7:0] regWriteData, // write data
   output logic [7:0] regReadData, // read data, registered
   output logic regReadValid, // read data valid pulse
   input wire logic incValid, // counter event pulse
   input wire logic [9:0] incIndex, // indirect offset of counter to bump
   input wire logic [stat_read_pkg::INC_WIDTH-1:0] incAmount // amount to add
);

   typedef struct packed {
      stat_read_pkg::read_state_type state;
      logic [7:0] tableSel;
      logic [7:0] addrByte;
      logic perPort;
      logic overflow;
      logic valid;
      logic [stat_read_pkg::PER_PORT_WIDTH-1:0] value;
      logic [7:0] rdData;
      logic rdValid;
   } read_path_type;

   read_path_type s_r;
   read_path_type s_nxt;

   logic [stat_read_pkg::PER_PORT_WIDTH-1:0] portCount [0:stat_read_pkg::PER_PORT_CELLS-1];
   logic [stat_read_pkg::PER_PORT_CELLS-1:0] portOverflow;
   logic [stat_read_pkg::PER_PORT_CELLS-1:0] portClear;
   logic [stat_read_pkg::DROP_WIDTH-1:0] dropCount [0:stat_read_pkg::DROP_CELLS-1];
   logic perPortHit;
   logic dropHit;
   logic triggerWrite;

   // per-port cells sit at offset port*32+counter; offset 0xe of each block
   // is the 64-octet received frame counter
   genvar g;
   generate
      for (g = 0; g < stat_read_pkg::PER_PORT_CELLS; g++) begin : gen_port
         counter_cell #(
            .WIDTH(stat_read_pkg::PER_PORT_WIDTH)
         ) u_cell (
            .clock(clock),
            .reset_n(reset_n),
            .incEn(incValid && (incIndex == 10'(g))),
            .incAmount(incAmount),
            .clearEn(portClear[g]),
            .count(portCount[g]),
            .overflow(portOverflow[g])
         );
      end
   endgenerate

   // dropped-packet cells at 0x100..0x105, tx ports then rx ports; never
   // cleared by reads, so their wrap flag is left unconnected
   genvar d;
   generate
      for (d = 0; d < stat_read_pkg::DROP_CELLS; d++) begin : gen_drop
         counter_cell #(
            .WIDTH(stat_read_pkg::DROP_WIDTH)
         ) u_cell (
            .clock(clock),
            .reset_n(reset_n),
            .incEn(incValid && (incIndex == (stat_read_pkg::DROP_BASE + 10'(d)))),
            .incAmount(incAmount),
            .clearEn(1'b0),
            .count(dropCount[d]),
            .overflow()
         );
      end
   endgenerate

   // decode of the latched select and address bytes
   assign perPortHit = (s_r.tableSel == stat_read_pkg::SEL_PER_PORT) &&
                       (s_r.addrByte < stat_read_pkg::PER_PORT_LIMIT);
   assign dropHit = (s_r.tableSel == stat_read_pkg::SEL_DROPPED) &&
                    (s_r.addrByte < stat_read_pkg::DROP_LIMIT);
   assign triggerWrite = regWrite && (regAddr == stat_read_pkg::ADDR_ADDRESS_TRIGGER);

   // clear pulse for the per-port cell being fetched; the clear and the
   // latch happen in the same cycle so no event can slip between them
   always_comb begin
      portClear = '0;
      if ((s_r.state == stat_read_pkg::ST_FETCH) && perPortHit) begin
         portClear[s_r.addrByte[6:0]] = 1'b1;
      end
   end

   // register file, trigger sequencing and result latch
   always_comb begin
      s_nxt = s_r;
      s_nxt.rdValid = 1'b0;

      case (s_r.state)
         stat_read_pkg::ST_IDLE: begin
            s_nxt.state = stat_read_pkg::ST_IDLE;
         end
         stat_read_pkg::ST_FETCH: begin
            // capture one snapshot; it then stands until the next trigger
            s_nxt.state = stat_read_pkg::ST_IDLE;
            s_nxt.valid = 1'b1;
            s_nxt.perPort = !dropHit;
            s_nxt.overflow = 1'b0;
            s_nxt.value = '0;
            if (perPortHit) begin
               s_nxt.value = portCount[s_r.addrByte[6:0]];
               s_nxt.overflow = portOverflow[s_r.addrByte[6:0]];
            end else if (dropHit) begin
               s_nxt.value = {14'h0000, dropCount[s_r.addrByte[2:0]]};
            end
         end
         default: begin
            s_nxt.state = stat_read_pkg::ST_IDLE;
         end
      endcase

      // writes: a trigger restarts the fetch even if one is in flight
      if (regWrite) begin
         if (regAddr == stat_read_pkg::ADDR_TABLE_SELECT) begin
            s_nxt.tableSel = regWriteData;
         end
         if (triggerWrite) begin
            s_nxt.addrByte = regWriteData;
            s_nxt.state = stat_read_pkg::ST_FETCH;
            s_nxt.valid = 1'b0;
         end
      end

      // reads are side-effect free; unmapped addresses read zero
      if (regRead) begin
         s_nxt.rdValid = 1'b1;
         case (regAddr)
            stat_read_pkg::ADDR_TABLE_SELECT: begin
               s_nxt.rdData = s_r.tableSel;
            end
            stat_read_pkg::ADDR_ADDRESS_TRIGGER: begin
               s_nxt.rdData = s_r.addrByte;
            end
            stat_read_pkg::ADDR_RESULT_TOP: begin
               // drop results carry no flags or upper bits
               s_nxt.rdData = 8'h00;
               if (s_r.perPort) begin
                  s_nxt.rdData[stat_read_pkg::BIT_OVERFLOW] = s_r.overflow;
                  s_nxt.rdData[stat_read_pkg::BIT_VALID] = s_r.valid;
                  s_nxt.rdData[5:0] = s_r.value[29:24];
               end
            end
            stat_read_pkg::ADDR_RESULT_BYTE2: begin
               s_nxt.rdData = s_r.value[23:16];
            end
            stat_read_pkg::ADDR_RESULT_BYTE1: begin
               s_nxt.rdData = s_r.value[15:8];
            end
            stat_read_pkg::ADDR_RESULT_BYTE0: begin
               s_nxt.rdData = s_r.value[7:0];
            end
            default: begin
               s_nxt.rdData = 8'h00;
            end
         endcase
      end
   end

   // state register
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         s_r.state <= stat_read_pkg::ST_IDLE;
         s_r.tableSel <= stat_read_pkg::TABLE_SELECT_RESET;
         s_r.addrByte <= stat_read_pkg::ADDRESS_TRIGGER_RESET;
         s_r.perPort <= 1'b1;
         s_r.overflow <= 1'b0;
         s_r.valid <= 1'b0;
         s_r.value <= '0;
         s_r.rdData <= 8'h00;
         s_r.rdValid <= 1'b0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign regReadData = s_r.rdData;
   assign regReadValid = s_r.rdValid;

endmodule
`default_nettype wire

// ### verif/stat_read_sva.sv
// port checker for the indirect statistics read path
// assumes read answer and read data come from registers
`timescale 1ns/100ps
`default_nettype none
module stat_read_sva (
   input wire logic clock, // clock
   input wire logic reset_n, // reset
   input wire logic regWrite, // write
   input wire logic regRead, // read
   input wire logic [7:0] regAddr, // address
   input wire logic [7:0] regWriteData, // write data
   input wire logic [7:0] regReadData, // read data
   input wire logic regReadValid // answer
);
   logic [7:0] selR, selT, adrT; // select, select and offset at trigger
   logic [1:0] age; // edges since trigger, saturates at 3
   wire lone = regRead && !regWrite;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);
   // age 1 is the fetch cycle, so the result is not yet fresh there
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         selR <= 8'h00;
         age <= 2'h0;
      end else begin
         if (regWrite && regAddr == 8'h79) begin
            selR <= regWriteData;
         end
         if (regWrite && regAddr == 8'h7a) begin
            selT <= selR;
            adrT <= regWriteData;
            age <= 2'h1;
         end else if (age == 2'h1 || age == 2'h2) begin
            age <= age + 2'h1;
         end
      end
   end
   AST_ANSWER: assert property (regRead |=> regReadValid) else $error("no answer");
   AST_NO_EXTRA: assert property (!regRead |=> !regReadValid) else $error("stray");
   AST_HOLD: assert property (!regReadValid |-> $stable(regReadData)) else $error("drift");
   AST_SEL_BACK: assert property (lone && regAddr == 8'h79 |=> regReadData == $past(selR))
      else $error("select readback");
   AST_UNMAPPED: assert property (lone && !(regAddr inside {8'h79, 8'h7a, [8'h80:8'h83]})
      |=> regReadData == 8'h00) else $error("unmapped");
   AST_STALE: assert property (lone && age == 2'h1 && regAddr == 8'h80 |=> !regReadData[6])
      else $error("early valid");
   AST_VALID: assert property (lone && age[1] && selT != 8'h1d && regAddr == 8'h80
      |=> regReadData[6]) else $error("valid low");
   AST_DROP_TOP: assert property (lone && age[1] && selT == 8'h1d && adrT < 8'h06
      && regAddr inside {8'h80, 8'h81} |=> regReadData == 8'h00) else $error("drop top");
   cover property (lone && age == 2'h1 && regAddr == 8'h80);
   cover property (lone && age[1] && selT == 8'h1c && regAddr == 8'h80);
   cover property (lone && age[1] && selT == 8'h1d && regAddr == 8'h82);
endmodule
bind statistics_counter_indirect_read stat_read_sva stat_read_sva_inst (.clock, .reset_n,
   .regWrite, .regRead, .regAddr, .regWriteData, .regReadData, .regReadValid);
`default_nettype wire

// ### verif/stat_host.sv
// management host model on the byte register bus
// assumes a read is answered one cycle after it is taken
`timescale 1ns/100ps
`default_nettype none
module stat_host (
   input wire logic clock, // system clock
   input wire logic regReadValid, // read answer
   input wire logic [7:0] regReadData, // read data
   output logic regWrite, // write strobe
   output logic regRead, // read strobe
   output logic [7:0] regAddr, // address
   output logic [7:0] regWriteData // write data
);
   initial begin
      regWrite = 1'b0;
      regRead = 1'b0;
      regAddr = 8'h00;
      regWriteData = 8'h00;
   end
   // select then trigger writes; released lines show inverted values
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      regWrite <= 1'b1;
      regAddr <= a;
      regWriteData <= d;
      @(posedge clock);
      regWrite <= 1'b0;
      regAddr <= ~a;
      regWriteData <= ~d;
   endtask
   // read issued now, answer taken after the next edge settles
   task automatic get(input logic [7:0] a, output logic [8:0] q);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge clock);
      regRead <= 1'b0;
      regAddr <= ~a;
      // the answer pulse stands for the one cycle after the read edge only
      #1 q = {regReadValid, regReadData};
   endtask
   task automatic rd(input logic [7:0] a, output logic [8:0] q);
      @(posedge clock);
      get(a, q);
   endtask
   // trigger then read the top byte at once; caller rereads while invalid
   // drop counts carry no flags, so the caller keeps its own
   // a real host polls every counter within 30 seconds; runs here are short
   task automatic peek(input logic [7:0] a, output logic [8:0] q);
      @(posedge clock);
      regWrite <= 1'b1;
      regAddr <= 8'h7a;
      regWriteData <= a;
      @(posedge clock);
      regWrite <= 1'b0;
      get(8'h80, q);
   endtask
endmodule
`default_nettype wire

// ### verif/statistics_counter_indirect_read_bench.sv
// self-checking bench: integer model of all counters against the device
// assumes the host model drives the register bus
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) chk(g, e)
module statistics_counter_indirect_read_bench;
   logic clock, reset_n, regWrite, regRead, regReadValid, incValid;
   logic [7:0] regAddr, regWriteData, regReadData, last;
   logic [9:0] incIndex;
   logic [stat_read_pkg::INC_WIDTH-1:0] incAmount;
   logic [8:0] q;
   int errors, n_tests, k;
   int unsigned cnt[96], drp[6];
   bit ovf[96];
   statistics_counter_indirect_read statistics_counter_indirect_read_inst (.clock, .reset_n,
      .regWrite, .regRead, .regAddr, .regWriteData, .regReadData, .regReadValid, .incValid,
      .incIndex, .incAmount);
   stat_host host (.clock, .regReadValid, .regReadData, .regWrite, .regRead, .regAddr,
      .regWriteData);
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   task automatic chk(input logic [8:0] g, input logic [8:0] e);
      n_tests++;
      if (g !== e) begin
         errors++;
         $display("[FAIL] %0t got %h expected %h", $time, g, e);
      end
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // one event per edge; the model wraps like the device
   task automatic inc(input int i, input int a);
      @(posedge clock);
      incValid <= 1'b1;
      incIndex <= 10'(i);
      incAmount <= 16'(a);
      if (i < 96) begin
         ovf[i] |= (cnt[i] + a >= 2**30);
         cnt[i] = (cnt[i] + a) % 2**30;
      end else begin
         drp[i - 256] = (drp[i - 256] + a) % 2**16;
      end
   endtask
   // full indirect read of one counter, all four result bytes
   task automatic readCnt(input logic [7:0] s, input logic [7:0] a);
      logic [31:0] v;
      v = (s == 8'h1c) ? {ovf[a], 1'b1, 30'(cnt[a])} : 32'(drp[a]);
      host.wr(8'h79, s);
      host.wr(8'h7a, a);
      for (int b = 0; b < 4; b++) begin
         host.rd(8'(8'h80 + b), q);
         `CHK(q, {1'b1, v[31 - 8 * b -: 8]});
      end
      if (s == 8'h1c) begin
         cnt[a] = 0;
         ovf[a] = 0;
      end
      last = v[7:0];
   endtask
   initial begin
      reset_n = 1'b0;
      incValid = 1'b0;
      incIndex = 10'h000;
      incAmount = 16'h0000;
      void'($urandom(76));
      repeat (10) @(posedge clock);
      reset_n <= 1'b1;
      host.rd(8'h79, q);
      `CHK(q, 9'h100);
      host.wr(8'h83, 8'h5a);
      host.rd(8'h83, q);
      `CHK(q, 9'h100);
      host.rd(8'h90, q);
      `CHK(q, 9'h100);
      $display("reset test done");
      inc(14, 7);
      inc(46, 9);
      repeat (200) inc($urandom % 2 ? $urandom % 96 : 256 + $urandom % 6, $urandom % 65536);
      @(posedge clock) incValid <= 1'b0;
      readCnt(8'h1c, 8'h0e);
      readCnt(8'h1c, 8'h2e);
      repeat (4) readCnt(8'h1c, 8'($urandom % 96));
      readCnt(8'h1c, 8'h0e);
      for (int d = 0; d < 6; d++) begin
         repeat (2) readCnt(8'h1d, 8'(d));
      end
      $display("traffic test done");
      readCnt(8'h1c, 8'h2e);
      inc(46, 5);
      @(posedge clock) incValid <= 1'b0;
      host.rd(8'h83, q);
      `CHK(q, {1'b1, last});
      $display("hold test done");
      host.peek(8'h2e, q);
      `CHK(q & 9'h140, 9'h100);
      cnt[46] = 0;
      k = 0;
      while (k < 8 && q[6] !== 1'b1) begin
         host.rd(8'h80, q);
         k++;
      end
      `CHK({8'h00, q[6]}, 9'h001);
      $display("valid test done");
      repeat (16385) inc(14, 65535);
      @(posedge clock) incValid <= 1'b0;
      readCnt(8'h1c, 8'h0e);
      readCnt(8'h1c, 8'h0e);
      $display("overflow test done");
      summarize();
   end
endmodule
`default_nettype wire
